// ===== rtl/tmr_defines.svh
// constants for the sixteen-bit timer: offsets, fields, resets, timing
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// register offsets
`define TMR_ADDR_CTRL      8'h05
`define TMR_ADDR_IRQ       8'h07
`define TMR_ADDR_CNT_LO    8'h0B
`define TMR_ADDR_CNT_HI    8'h0C

// timer_control fields
`define TMR_CTRL_EXT_EDGE  7
`define TMR_CTRL_EDGE_SEL  6
`define TMR_CTRL_CLK_SRC   5
`define TMR_CTRL_PS_HI     4
`define TMR_CTRL_PS_LO     1
`define TMR_CTRL_RESET     8'h00

// interrupt_status_enable fields
`define TMR_IRQ_PIN_FLAG   6
`define TMR_IRQ_OVF_FLAG   5
`define TMR_IRQ_PIN_EN     2
`define TMR_IRQ_OVF_EN     1
`define TMR_IRQ_RESET      8'h00

// timing: oscillator periods per instruction cycle, edge delay window
`define TMR_TOSC_NS        40
`define TMR_TOSC_PER_INSTR 4
`define TMR_DLY_MIN_TOSC   3
`define TMR_DLY_MAX_TOSC   7

// prescaler width and the code bit that forces 1:256
`define TMR_PS_WIDTH       8
`define TMR_PS_MAX_BIT     3

`endif

// ===== rtl/tmr_pkg.sv
// types shared by the sixteen-bit timer
package tmr_pkg;

  // instruction cycle phases, one-hot
  typedef enum logic [3:0] {
    TMR_PH_Q1 = 4'b0001,
    TMR_PH_Q2 = 4'b0010,
    TMR_PH_Q3 = 4'b0100,
    TMR_PH_Q4 = 4'b1000
  } tmr_phase_t;

endpackage

// ===== rtl/tmr_timer.sv
// sixteen-bit timer/counter with eight-bit prescaler and register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "tmr_defines.svh"

// Function
// [R1] external count goes through prescaler first, then syncs to phases
// [R2] prescaler output sampled twice per instruction cycle; each transition counts
// [R3] count advances 3 to 7 oscillator periods after active pin edge
// [R4] 16-bit count reached as two byte registers, one per access
// [R5] write to one half blocks that half's increment next cycle only
// [R6] any write to either count byte clears the prescaler count
// [R7] software loads low byte then high byte, interrupts off
// [R8] software re-reads both bytes if low byte went down
// [R9] prescale ratio may change while the counter runs
// [R10] software should clear prescaler before changing the ratio
// [R11] prescaler count is not readable by software
// [R12] count bytes at 0Bh and 0Ch, not touched by any reset
// [R13] clock source bit picks instruction clock or pin; edge bit picks polarity
// [R14] four-bit prescale code gives 1:1 up to 1:256 when top bit set
// [R15] count wraps FFFFh to 0000h, setting a maskable overflow flag
// [R16] overflow flag clears when the processor vectors to it
// [R17] internal mode feeds one pulse per instruction cycle into prescaler
module tmr_timer
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // external count pin, asynchronous
  input  wire logic       external_count_pin_in,
  // processor vectoring to the overflow interrupt
  input  wire logic       ovf_vector_ack_in,
  // interrupt request, level
  output logic            irq_out
);

  // ratio minus one for a prescale code
  function automatic logic [7:0] ps_limit(input logic [3:0] code);
    logic [7:0] lim;
    lim = 8'h00;
    if (code[`TMR_PS_MAX_BIT]) begin
      lim = 8'hFF; // [R14]
    end else begin
      lim = 8'(({1'b0, 8'h01} << code[2:0]) - 9'h001); // [R14]
    end
    return lim;
  endfunction

  // address hit for a write
  function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                  input logic [7:0] target);
    return w && (a == target);
  endfunction

  tmr_phase_t  phase_reg;
  tmr_phase_t  phase_next;
  logic [7:0]  ctrl_reg;
  logic        pin_flag_reg;
  logic        ovf_flag_reg;
  logic        pin_en_reg;
  logic        ovf_en_reg;
  logic [7:0]  cnt_lo_reg;
  logic [7:0]  cnt_hi_reg;
  logic        lo_inh_reg;
  logic        hi_inh_reg;
  logic        pin_s1_reg;
  logic        pin_s2_reg;
  logic        pin_prev_reg;
  logic [7:0]  ps_cnt_reg;
  logic        prescaler_output;
  logic        ps_samp_reg;
  logic        ps_last_reg;
  logic [7:0]  rdata_reg;
  logic        edge_select;
  logic        clock_source_select;
  logic [3:0]  prescale_select;
  logic        pin_edge;
  logic        ps_in;
  logic        instr_tick;
  logic        sample_tick;
  logic        count_inc;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_ctrl;
  logic        wr_irq;
  logic        lo_step;
  logic        hi_step;
  logic        ovf_event;

  assign edge_select         = ctrl_reg[`TMR_CTRL_EDGE_SEL];
  assign clock_source_select = ctrl_reg[`TMR_CTRL_CLK_SRC];
  assign prescale_select     = ctrl_reg[`TMR_CTRL_PS_HI:`TMR_CTRL_PS_LO];

  // write decode
  assign wr_ctrl = wr_hit(wr_in, addr_in, `TMR_ADDR_CTRL);
  assign wr_irq  = wr_hit(wr_in, addr_in, `TMR_ADDR_IRQ);
  assign wr_lo   = wr_hit(wr_in, addr_in, `TMR_ADDR_CNT_LO); // [R4]
  assign wr_hi   = wr_hit(wr_in, addr_in, `TMR_ADDR_CNT_HI); // [R4]

  // four-phase instruction cycle sequencer
  always_comb begin
    phase_next = TMR_PH_Q1;
    unique case (phase_reg)
      TMR_PH_Q1: phase_next = TMR_PH_Q2;
      TMR_PH_Q2: phase_next = TMR_PH_Q3;
      TMR_PH_Q3: phase_next = TMR_PH_Q4;
      TMR_PH_Q4: phase_next = TMR_PH_Q1;
      default:   phase_next = TMR_PH_Q1;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      phase_reg <= TMR_PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // one pulse per four oscillator periods
  assign instr_tick  = (phase_reg == TMR_PH_Q4); // [R17]
  // two sample points per instruction cycle
  assign sample_tick = (phase_reg == TMR_PH_Q2) || (phase_reg == TMR_PH_Q4); // [R2]

  // pin synchroniser; only the second and third stages feed logic
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= external_count_pin_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // selected pin polarity
  assign pin_edge = edge_select ? (pin_s2_reg && !pin_prev_reg)
                                : (!pin_s2_reg && pin_prev_reg); // [R13]

  // prescaler input: instruction clock or pin edge
  assign ps_in = clock_source_select ? instr_tick : pin_edge; // [R13] [R17]

  // prescaler; its output toggles once per ratio of input pulses.
  // the count is never put on the read path
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ps_cnt_reg       <= 8'h00;
      prescaler_output <= 1'b0;
    end else if (wr_lo || wr_hi) begin
      ps_cnt_reg <= 8'h00; // [R6]
    end else if (ps_in) begin
      // ratio is read live, so a change takes hold at once
      if (ps_cnt_reg == ps_limit(prescale_select)) begin // [R9] [R14]
        ps_cnt_reg       <= 8'h00;
        prescaler_output <= !prescaler_output; // [R1]
      end else begin
        ps_cnt_reg <= ps_cnt_reg + 8'h01; // [R11]
      end
    end
  end

  // sample prescaler output at the two sample phases
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ps_samp_reg <= 1'b0;
      ps_last_reg <= 1'b0;
    end else begin
      if (sample_tick) begin
        ps_samp_reg <= prescaler_output; // [R1] [R2]
      end
      ps_last_reg <= ps_samp_reg;
    end
  end

  // either transition of the sampled output advances the count;
  // worst-case latency from pin edge stays within the delay window
  assign count_inc = (ps_samp_reg != ps_last_reg); // [R2] [R3]

  // write-inhibit markers, one cycle after each byte write
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lo_inh_reg <= 1'b0;
      hi_inh_reg <= 1'b0;
    end else begin
      lo_inh_reg <= wr_lo; // [R5]
      hi_inh_reg <= wr_hi; // [R5]
    end
  end

  assign lo_step   = count_inc && !wr_lo && !lo_inh_reg; // [R5]
  assign hi_step   = lo_step && (cnt_lo_reg == 8'hFF)
                     && !wr_hi && !hi_inh_reg; // [R5] [R15]
  assign ovf_event = hi_step && (cnt_hi_reg == 8'hFF); // [R15]

  // main_counter low byte; no reset so value survives all resets
  always_ff @(posedge mclk_in) begin
    if (wr_lo) begin
      cnt_lo_reg <= wdata_in; // [R4]
    end else if (lo_step) begin
      cnt_lo_reg <= cnt_lo_reg + 8'h01; // [R15]
    end
  end

  // main_counter high byte; no reset, same as low byte
  always_ff @(posedge mclk_in) begin
    if (wr_hi) begin
      cnt_hi_reg <= wdata_in; // [R4]
    end else if (hi_step) begin
      cnt_hi_reg <= cnt_hi_reg + 8'h01; // [R15]
    end
  end

  // timer_control register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_reg <= `TMR_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {wdata_in[7:1], 1'b0}; // bit 0 unimplemented
    end
  end

  // interrupt enables
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_en_reg <= 1'b0;
      ovf_en_reg <= 1'b0;
    end else if (wr_irq) begin
      pin_en_reg <= wdata_in[`TMR_IRQ_PIN_EN];
      ovf_en_reg <= wdata_in[`TMR_IRQ_OVF_EN]; // [R15]
    end
  end

  // sticky flags: set wins over write-one clear and vector clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ovf_flag_reg <= 1'b0;
      pin_flag_reg <= 1'b0;
    end else begin
      if (ovf_event) begin
        ovf_flag_reg <= 1'b1; // [R15]
      end else if (ovf_vector_ack_in ||
                   (wr_irq && wdata_in[`TMR_IRQ_OVF_FLAG])) begin
        ovf_flag_reg <= 1'b0; // [R16]
      end
      if (pin_edge) begin
        pin_flag_reg <= 1'b1;
      end else if (wr_irq && wdata_in[`TMR_IRQ_PIN_FLAG]) begin
        pin_flag_reg <= 1'b0;
      end
    end
  end

  // level interrupt while an enabled flag stands
  assign irq_out = (ovf_flag_reg && ovf_en_reg) || (pin_flag_reg && pin_en_reg); // [R15]

  // read data, valid the cycle after the strobe only
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        `TMR_ADDR_CTRL:   rdata_reg <= ctrl_reg;
        `TMR_ADDR_IRQ:    rdata_reg <= {1'b0, pin_flag_reg, ovf_flag_reg, 2'b00,
                                        pin_en_reg, ovf_en_reg, 1'b0};
        `TMR_ADDR_CNT_LO: rdata_reg <= cnt_lo_reg; // [R12]
        `TMR_ADDR_CNT_HI: rdata_reg <= cnt_hi_reg; // [R12]
        default:          rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_out = rdata_reg;

endmodule // tmr_timer

// ===== tb/tmr_pin_src.sv
// external count pin source: bursts of square pulses
`timescale 1ns/1ns
module tmr_pin_src (
  // clock
  input  wire logic       clk_in,
  // burst request
  input  wire logic       go_in,
  input  wire logic [7:0] pulses_in,
  // pin and state
  output logic            pin_out = 1'b0,
  output logic            busy_out
);
  logic [7:0] left_reg = 8'h00;
  logic [1:0] tick_reg = 2'h0;
  assign busy_out = (left_reg != 8'h00);
  // four clocks per level so every edge survives the sampling; idles low
  always_ff @(posedge clk_in) begin
    if (go_in && !busy_out) begin
      left_reg <= {pulses_in[6:0], 1'b0};
    end else if (busy_out) begin
      tick_reg <= tick_reg + 2'h1;
      if (tick_reg == 2'h3) begin
        pin_out  <= ~pin_out;
        left_reg <= left_reg - 8'h01;
      end
    end
  end
endmodule // tmr_pin_src

// ===== tb/tmr_timer_sva.sv
// checker for the timer register port and interrupt line
`timescale 1ns/1ns
module tmr_timer_sva (
  // clock and reset
  input wire logic       mclk_in,
  input wire logic       rst_in,
  // register port and interrupt
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_out
);
  // decoded accesses
  wire wlo = wr_in && addr_in == 8'h0B;
  wire rlo = rd_in && addr_in == 8'h0B;
  wire whi = wr_in && addr_in == 8'h0C;
  wire rhi = rd_in && addr_in == 8'h0C;
  wire wct = wr_in && addr_in == 8'h05;
  wire rct = rd_in && addr_in == 8'h05;
  wire wiq = wr_in && addr_in == 8'h07;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  reset_quiet_a: assert property ($fell(rst_in) |-> rdata_out == 8'h00 && !irq_out)
    else $error("outputs busy after reset");
  unmapped_zero_a: assert property (rd_in && addr_in > 8'h0C |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  ctrl_bit0_a: assert property (rct |=> !rdata_out[0])
    else $error("control bit 0 set");
  ctrl_back_a: assert property (wct ##1 rct |=> {rdata_out[7:1], 1'b0} == ($past(wdata_in, 2) & 8'hFE))
    else $error("control readback wrong");
  low_hold_a: assert property (wlo ##1 rlo |=> rdata_out == $past(wdata_in, 2))
    else $error("low byte moved after write");
  high_hold_a: assert property (whi ##1 rhi |=> rdata_out == $past(wdata_in, 2))
    else $error("high byte moved after write");
  irq_mask_a: assert property (wiq && wdata_in[2:1] == 2'b00 |=> !irq_out)
    else $error("masked interrupt raised");
endmodule // tmr_timer_sva

bind tmr_timer tmr_timer_sva u_sva (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out)
);

// ===== tb/tmr_timer_test.sv
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_timer_test;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] pulses; logic [7:0] cnt;} tmr_row_t;
  // control value, pin pulses, expected low byte
  tmr_row_t rows [5] = '{'{8'h40, 8'h05, 8'h05}, '{8'h00, 8'h05, 8'h05},
    '{8'h42, 8'h08, 8'h04}, '{8'h46, 8'h10, 8'h02}, '{8'h50, 8'h08, 8'h00}};
  logic       mclk, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pulses = 8'h00, rdata;
  logic       pin, irq, busy;
  int         errors = 0, total_checks = 0, cycles = 0;
  logic [7:0] lo1, hi1, lo2;

  tmr_timer dut (.mclk_in(mclk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .external_count_pin_in(pin),
    .ovf_vector_ack_in(ack), .irq_out(irq));
  tmr_pin_src src (.clk_in(mclk), .go_in(go), .pulses_in(pulses), .pin_out(pin),
    .busy_out(busy));

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
    total_checks++;
    if (got !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  // one bus cycle, entered just after a rising edge; strobes stay for a follower
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    acc(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(negedge mclk);
    chk(what, e, rdata);
    @(posedge mclk);
  endtask
  // one read that hands back the byte seen the cycle after the strobe
  task automatic rd_val(input logic [7:0] a, output logic [7:0] v);
    acc(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
    @(posedge mclk);
  endtask
  // write interrupt register, or pulse the vector ack, then look at irq_out
  task automatic irq_chk(input logic v, input logic [7:0] d, input logic e);
    if (v) ack <= 1'b1;
    else acc(1'b1, 1'b0, `TMR_ADDR_IRQ, d);
    if (v) @(posedge mclk);
    wr <= 1'b0;
    ack <= 1'b0;
    @(negedge mclk);
    chk("irq_out", {7'h00, e}, {7'h00, irq});
    @(posedge mclk);
  endtask
  task automatic wrap_up();
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_LO, 8'hFF);
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_HI, 8'hFF);
    wr <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // hang guard: the run needs about 520 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b0, `TMR_ADDR_CNT_LO, 8'h00);
      acc(1'b1, 1'b0, `TMR_ADDR_CNT_HI, 8'h00);
      acc(1'b1, 1'b0, `TMR_ADDR_CTRL, rows[i].ctrl);
      wr <= 1'b0;
      go <= 1'b1;
      pulses <= rows[i].pulses;
      @(posedge mclk);
      go <= 1'b0;
      repeat (300) begin
        @(posedge mclk);
        if (!busy) break;
      end
      repeat (12) @(posedge mclk);
      rd_chk(`TMR_ADDR_CNT_LO, rows[i].cnt, "count_low_byte");
    end
    // mid-run reset, then reset values and odd addresses
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(`TMR_ADDR_CTRL, `TMR_CTRL_RESET, "timer_control");
    rd_chk(`TMR_ADDR_IRQ, `TMR_IRQ_RESET, "interrupt_status_enable");
    rd_chk(8'h20, 8'h00, "unmapped");
    acc(1'b1, 1'b0, `TMR_ADDR_CTRL, 8'h20);
    rd_chk(`TMR_ADDR_CTRL, 8'h20, "timer_control");
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_LO, 8'h10);
    rd_chk(`TMR_ADDR_CNT_LO, 8'h10, "count_low_byte");
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_HI, 8'h34);
    rd_chk(`TMR_ADDR_CNT_HI, 8'h34, "count_high_byte");
    // overflow raised, masked, unmasked, then cleared two ways
    irq_chk(1'b0, 8'h02, 1'b0);
    wrap_up();
    rd_chk(`TMR_ADDR_IRQ, 8'h22, "interrupt_status_enable");
    rd_chk(`TMR_ADDR_CNT_HI, 8'h00, "count_high_byte");
    irq_chk(1'b0, 8'h00, 1'b0);
    irq_chk(1'b0, 8'h02, 1'b1);
    irq_chk(1'b1, 8'h00, 1'b0);
    wrap_up();
    irq_chk(1'b0, 8'h22, 1'b0);
    rd_chk(`TMR_ADDR_IRQ, 8'h02, "interrupt_status_enable");
    // 16-bit read just before a low-byte wrap; re-read if the low byte went down
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_LO, 8'hFE);
    acc(1'b1, 1'b0, `TMR_ADDR_CNT_HI, 8'h12);
    rd_val(`TMR_ADDR_CNT_LO, lo1);
    rd_val(`TMR_ADDR_CNT_HI, hi1);
    rd_val(`TMR_ADDR_CNT_LO, lo2);
    if (lo2 < lo1) begin
      rd_val(`TMR_ADDR_CNT_LO, lo1);
      rd_val(`TMR_ADDR_CNT_HI, hi1);
    end
    chk("main_counter", 8'h01,
        {7'h00, ({hi1, lo1} >= 16'h12FE) && ({hi1, lo1} <= 16'h1310)});
    stop_test();
  end
endmodule // tmr_timer_test
